// *** pam_pkg.sv ***
// constants, field layout and carrier types of the upper port pin function select
// assumes a classic wishbone master with a 32-bit data path
package pam_pkg;

    // ==========================================================
    // bus geometry
    localparam int          PAM_DW       = 32;
    localparam int          PAM_AW       = 4;
    localparam int          PAM_SW       = 4;
    localparam int          PAM_REG_W    = 16;
    localparam int          PAM_LANE_W   = 8;
    localparam logic [3:0]  PAM_ADR_FUNC = 4'h0;

    // ==========================================================
    // register layout
    localparam logic [15:0] PAM_FUNC_RST   = 16'h0000;
    localparam logic [15:0] PAM_FUNC_WMASK = 16'h7777;
    localparam int          PAM_CODE_W     = 3;
    localparam int          PAM_P8_LSB     = 0;
    localparam int          PAM_P9_LSB     = 4;
    localparam int          PAM_P10_LSB    = 8;
    localparam int          PAM_P11_LSB    = 12;
    localparam int          PAM_RSV3       = 3;
    localparam int          PAM_RSV7       = 7;
    localparam int          PAM_RSV11      = 11;
    localparam int          PAM_RSV15      = 15;
    localparam int          PAM_LANE0_SEL  = 0;
    localparam int          PAM_LANE1_SEL  = 1;

    // ==========================================================
    // function codes
    localparam logic [2:0]  PAM_CODE_PORT    = 3'h0;
    localparam logic [2:0]  PAM_CODE_TIMER   = 3'h1;
    localparam logic [2:0]  PAM_CODE_TRIGGER = 3'h2;
    localparam logic [2:0]  PAM_CODE_SERIAL  = 3'h6;
    localparam logic [2:0]  PAM_CODE_DISABLE = 3'h7;

    // ==========================================================
    // pins, levels and variants
    localparam int          PAM_PIN_N   = 4;
    localparam int          PAM_PIN8    = 0;
    localparam int          PAM_PIN9    = 1;
    localparam int          PAM_PIN10   = 2;
    localparam int          PAM_PIN11   = 3;
    localparam logic        PAM_IN_IDLE = 1'b1;
    localparam logic        PAM_EMU_ON  = 1'b0;
    localparam int          PAM_MEM_32K = 32;
    localparam int          PAM_MEM_16K = 16;
    localparam int          PAM_MEM_DEF = 64;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic                 cyc;
        logic                 stb;
        logic                 we;
        logic [PAM_AW-1:0]    adr;
        logic [PAM_SW-1:0]    sel;
        logic [PAM_DW-1:0]    dat;
    } pam_wb_req_t;

    typedef struct packed {
        logic                 ack;
        logic [PAM_DW-1:0]    dat;
    } pam_wb_rsp_t;

endpackage

// *** pam_wb_reg.sv ***
// wishbone classic slave holding the pin function select register
// assumes the master holds its request until it samples ack
`timescale 1ns/1ns
module pam_wb_reg
    import pam_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire pam_wb_req_t          wb_req_i,
    output pam_wb_rsp_t               wb_rsp_o,
    output logic [PAM_REG_W-1:0]      func_sel_o
);

    // ==========================================================
    // decode
    logic                 ack_ff;
    logic [PAM_DW-1:0]    dat_ff;
    logic [PAM_REG_W-1:0] func_ff;
    logic [PAM_REG_W-1:0] nxt_func;
    logic [PAM_REG_W-1:0] lane_mask;

    wire bus_hit   = wb_req_i.cyc & wb_req_i.stb;
    wire adr_hit   = (wb_req_i.adr == PAM_ADR_FUNC);
    wire wr_commit = bus_hit & ack_ff & wb_req_i.we & adr_hit;
    wire rd_take   = bus_hit & ~ack_ff;

    assign lane_mask = {{PAM_LANE_W{wb_req_i.sel[PAM_LANE1_SEL]}},
                        {PAM_LANE_W{wb_req_i.sel[PAM_LANE0_SEL]}}};
    // reserved bits never store
    assign nxt_func  = (func_ff & ~(lane_mask & PAM_FUNC_WMASK))
                     | (wb_req_i.dat[PAM_REG_W-1:0] & lane_mask & PAM_FUNC_WMASK);

    wire [PAM_DW-1:0] rd_word = adr_hit ? {{(PAM_DW-PAM_REG_W){1'b0}}, func_ff & PAM_FUNC_WMASK}
                                        : {PAM_DW{1'b0}};

    // ==========================================================
    // state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff  <= 1'b0;
            dat_ff  <= {PAM_DW{1'b0}};
            func_ff <= PAM_FUNC_RST;
        end else if (ce_i) begin
            ack_ff <= rd_take;
            if (rd_take) begin
                dat_ff <= rd_word;
            end
            if (wr_commit) begin
                func_ff <= nxt_func;
            end
        end
    end

    assign wb_rsp_o.ack = ack_ff;
    assign wb_rsp_o.dat = dat_ff;
    assign func_sel_o   = func_ff;

endmodule

// *** pam_pin_mux.sv ***
// function routing of port pins eight to eleven
// assumes pads, port logic and peripherals sit on the same clock as the bus
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
// Operation
// - reserved bits read zero, written zero
// - pin eleven: port, trigger or serial0 transmit
// - pin ten: port or serial0 receive
// - pin nine: port, timer d, serial2, disable
// - emulator mode forces pin nine to TDO
// - pin eight: port, timer c, serial2 receive
// - emulator mode forces pin eight to TDI
// - all fields reset to port function
// - no emulator override on small variants
module pam_pin_mux
    import pam_pkg::*;
#(
    parameter int MEM_KBYTE = PAM_MEM_DEF
)
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire pam_wb_req_t           wb_req_i,
    output pam_wb_rsp_t                wb_rsp_o,
    input  wire logic                  debug_emulator_mode_pin_i,
    input  wire logic [PAM_PIN_N-1:0]  pad_in_i,
    output logic [PAM_PIN_N-1:0]       pad_out_o,
    output logic [PAM_PIN_N-1:0]       pad_oe_o,
    input  wire logic [PAM_PIN_N-1:0]  gpio_out_i,
    input  wire logic [PAM_PIN_N-1:0]  gpio_oe_i,
    output logic [PAM_PIN_N-1:0]       gpio_in_o,
    input  wire logic                  serial0_transmit_out_i,
    input  wire logic                  serial2_transmit_out_i,
    input  wire logic                  jtag_tdo_i,
    input  wire logic                  jtag_tdo_en_i,
    output logic                       converter_external_trigger_in_o,
    output logic                       serial0_receive_in_o,
    output logic                       serial2_receive_in_o,
    output logic                       timer_clock_c_in_o,
    output logic                       timer_clock_d_in_o,
    output logic                       output_disable_request_8_in_o,
    output logic                       jtag_tdi_o,
    output logic                       emulator_override_o,
    output logic [PAM_PIN_N-1:0]       port_mode_o
);

    // ==========================================================
    // register
    logic [PAM_REG_W-1:0] func_sel;

    pam_wb_reg u_reg (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .wb_req_i   (wb_req_i),
        .wb_rsp_o   (wb_rsp_o),
        .func_sel_o (func_sel)
    );

    // ==========================================================
    // field split
    wire [PAM_CODE_W-1:0] pin_eight_function_code  = func_sel[PAM_P8_LSB  +: PAM_CODE_W];
    wire [PAM_CODE_W-1:0] pin_nine_function_code   = func_sel[PAM_P9_LSB  +: PAM_CODE_W];
    wire [PAM_CODE_W-1:0] pin_ten_function_code    = func_sel[PAM_P10_LSB +: PAM_CODE_W];
    wire [PAM_CODE_W-1:0] pin_eleven_function_code = func_sel[PAM_P11_LSB +: PAM_CODE_W];

    // ==========================================================
    // emulator override
    localparam bit EMU_ALLOWED = (MEM_KBYTE != PAM_MEM_32K) && (MEM_KBYTE != PAM_MEM_16K);

    // small variants have no emulator path at all
    wire emu_on = EMU_ALLOWED && (debug_emulator_mode_pin_i == PAM_EMU_ON);

    // ==========================================================
    // function decode
    // unlisted codes select nothing: pad released, peripheral input idle
    wire p11_port = (pin_eleven_function_code == PAM_CODE_PORT);
    wire p11_trig = (pin_eleven_function_code == PAM_CODE_TRIGGER);
    wire p11_tx0  = (pin_eleven_function_code == PAM_CODE_SERIAL);

    wire p10_port = (pin_ten_function_code == PAM_CODE_PORT);
    wire p10_rx0  = (pin_ten_function_code == PAM_CODE_SERIAL);

    wire p9_tdo   = emu_on;
    wire p9_port  = ~emu_on & (pin_nine_function_code == PAM_CODE_PORT);
    wire p9_tclk  = ~emu_on & (pin_nine_function_code == PAM_CODE_TIMER);
    wire p9_tx2   = ~emu_on & (pin_nine_function_code == PAM_CODE_SERIAL);
    wire p9_odr   = ~emu_on & (pin_nine_function_code == PAM_CODE_DISABLE);

    wire p8_tdi   = emu_on;
    wire p8_port  = ~emu_on & (pin_eight_function_code == PAM_CODE_PORT);
    wire p8_tclk  = ~emu_on & (pin_eight_function_code == PAM_CODE_TIMER);
    wire p8_rx2   = ~emu_on & (pin_eight_function_code == PAM_CODE_SERIAL);

    wire [PAM_PIN_N-1:0] port_sel = {p11_port, p10_port, p9_port, p8_port};

    // ==========================================================
    // peripheral drive onto the pads
    logic [PAM_PIN_N-1:0] alt_out;
    logic [PAM_PIN_N-1:0] alt_oe;

    assign alt_out[PAM_PIN11] = serial0_transmit_out_i;
    assign alt_oe[PAM_PIN11]  = p11_tx0;
    assign alt_out[PAM_PIN10] = 1'b0;
    assign alt_oe[PAM_PIN10]  = 1'b0;
    assign alt_out[PAM_PIN9]  = p9_tdo ? jtag_tdo_i : serial2_transmit_out_i;
    assign alt_oe[PAM_PIN9]   = p9_tdo ? jtag_tdo_en_i : p9_tx2;
    assign alt_out[PAM_PIN8]  = 1'b0;
    assign alt_oe[PAM_PIN8]   = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < PAM_PIN_N; gi = gi + 1) begin : g_pin
            assign pad_out_o[gi] = port_sel[gi] ? gpio_out_i[gi] : alt_out[gi];
            assign pad_oe_o[gi]  = port_sel[gi] ? gpio_oe_i[gi]  : alt_oe[gi];
            // port reads the pin level in every mode
            assign gpio_in_o[gi] = pad_in_i[gi];
        end
    endgenerate

    // ==========================================================
    // pads onto the peripheral inputs
    assign converter_external_trigger_in_o = p11_trig ? pad_in_i[PAM_PIN11] : PAM_IN_IDLE;
    assign serial0_receive_in_o            = p10_rx0  ? pad_in_i[PAM_PIN10] : PAM_IN_IDLE;
    assign timer_clock_d_in_o              = p9_tclk  ? pad_in_i[PAM_PIN9]  : PAM_IN_IDLE;
    assign output_disable_request_8_in_o   = p9_odr   ? pad_in_i[PAM_PIN9]  : PAM_IN_IDLE;
    assign timer_clock_c_in_o              = p8_tclk  ? pad_in_i[PAM_PIN8]  : PAM_IN_IDLE;
    assign serial2_receive_in_o            = p8_rx2   ? pad_in_i[PAM_PIN8]  : PAM_IN_IDLE;
    assign jtag_tdi_o                      = p8_tdi   ? pad_in_i[PAM_PIN8]  : PAM_IN_IDLE;

    assign emulator_override_o = emu_on;
    assign port_mode_o         = port_sel;

    // ==========================================================
    // checks
    wire wr_commit = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & wb_rsp_o.ack
                   & (wb_req_i.adr == PAM_ADR_FUNC);
    wire rd_ack    = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & wb_rsp_o.ack;
    wire [PAM_REG_W-1:0] chk_lane = {{PAM_LANE_W{wb_req_i.sel[PAM_LANE1_SEL]}},
                                     {PAM_LANE_W{wb_req_i.sel[PAM_LANE0_SEL]}}};

    property p_reserved_zero;
        @(posedge clk_i) disable iff (rst_i)
        rd_ack |-> (wb_rsp_o.dat[PAM_RSV15] == 1'b0) && (wb_rsp_o.dat[PAM_RSV11] == 1'b0)
                && (wb_rsp_o.dat[PAM_RSV7] == 1'b0) && (wb_rsp_o.dat[PAM_RSV3] == 1'b0)
                && (wb_rsp_o.dat[PAM_DW-1:PAM_REG_W] == '0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_reserved_store;
        @(posedge clk_i) disable iff (rst_i)
        (func_sel & ~PAM_FUNC_WMASK) == '0;
    endproperty
    a_reserved_store: assert property (p_reserved_store)
        else $error("reserved bit stored");

    property p_pin11_route;
        @(posedge clk_i) disable iff (rst_i)
        (pin_eleven_function_code == PAM_CODE_SERIAL)
            |-> pad_oe_o[PAM_PIN11] && (pad_out_o[PAM_PIN11] == serial0_transmit_out_i)
                && (converter_external_trigger_in_o == PAM_IN_IDLE);
    endproperty
    a_pin11_route: assert property (p_pin11_route)
        else $error("pin eleven serial route wrong");

    property p_pin11_trig;
        @(posedge clk_i) disable iff (rst_i)
        (pin_eleven_function_code == PAM_CODE_TRIGGER)
            |-> !pad_oe_o[PAM_PIN11] && (converter_external_trigger_in_o == pad_in_i[PAM_PIN11]);
    endproperty
    a_pin11_trig: assert property (p_pin11_trig)
        else $error("pin eleven trigger route wrong");

    property p_pin10_route;
        @(posedge clk_i) disable iff (rst_i)
        (pin_ten_function_code != PAM_CODE_SERIAL) |-> (serial0_receive_in_o == PAM_IN_IDLE);
    endproperty
    a_pin10_route: assert property (p_pin10_route)
        else $error("serial0 receive not idle");

    property p_pin9_route;
        @(posedge clk_i) disable iff (rst_i)
        (!emu_on && (pin_nine_function_code == PAM_CODE_DISABLE))
            |-> !pad_oe_o[PAM_PIN9] && (output_disable_request_8_in_o == pad_in_i[PAM_PIN9])
                && (timer_clock_d_in_o == PAM_IN_IDLE);
    endproperty
    a_pin9_route: assert property (p_pin9_route)
        else $error("pin nine disable route wrong");

    property p_pin9_emu;
        @(posedge clk_i) disable iff (rst_i)
        emu_on |-> (pad_out_o[PAM_PIN9] == jtag_tdo_i) && (pad_oe_o[PAM_PIN9] == jtag_tdo_en_i)
                && (output_disable_request_8_in_o == PAM_IN_IDLE);
    endproperty
    a_pin9_emu: assert property (p_pin9_emu)
        else $error("pin nine not forced to tdo");

    property p_pin8_route;
        @(posedge clk_i) disable iff (rst_i)
        (!emu_on && (pin_eight_function_code == PAM_CODE_TIMER))
            |-> (timer_clock_c_in_o == pad_in_i[PAM_PIN8])
                && (serial2_receive_in_o == PAM_IN_IDLE);
    endproperty
    a_pin8_route: assert property (p_pin8_route)
        else $error("pin eight timer route wrong");

    property p_pin8_emu;
        @(posedge clk_i) disable iff (rst_i)
        emu_on |-> (jtag_tdi_o == pad_in_i[PAM_PIN8]) && !pad_oe_o[PAM_PIN8]
                && (timer_clock_c_in_o == PAM_IN_IDLE);
    endproperty
    a_pin8_emu: assert property (p_pin8_emu)
        else $error("pin eight not forced to tdi");

    property p_reset_port;
        @(posedge clk_i)
        $past(rst_i) |-> (func_sel == PAM_FUNC_RST) && !wb_rsp_o.ack;
    endproperty
    a_reset_port: assert property (p_reset_port)
        else $error("register not at reset value");

    property p_no_emu_small;
        @(posedge clk_i) disable iff (rst_i)
        !EMU_ALLOWED |-> !emulator_override_o
            && (port_mode_o[PAM_PIN9] == (pin_nine_function_code == PAM_CODE_PORT));
    endproperty
    a_no_emu_small: assert property (p_no_emu_small)
        else $error("emulator override on small variant");

    property p_write_lands;
        @(posedge clk_i) disable iff (rst_i)
        (wr_commit && ce_i) |=> func_sel
            == (($past(wb_req_i.dat[PAM_REG_W-1:0]) & $past(chk_lane) & PAM_FUNC_WMASK)
              | ($past(func_sel) & ~($past(chk_lane) & PAM_FUNC_WMASK)));
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("write not seen next cycle");

    property p_route_holds;
        @(posedge clk_i) disable iff (rst_i)
        !(wr_commit && ce_i) |=> $stable(func_sel);
    endproperty
    a_route_holds: assert property (p_route_holds)
        else $error("routing changed without write");

    property p_ack_single;
        @(posedge clk_i) disable iff (rst_i)
        (wb_rsp_o.ack && ce_i) |=> !wb_rsp_o.ack;
    endproperty
    a_ack_single: assert property (p_ack_single)
        else $error("ack held two cycles");

    property p_pin11_port;
        @(posedge clk_i) disable iff (rst_i)
        (pin_eleven_function_code == PAM_CODE_PORT)
            |-> port_mode_o[PAM_PIN11] && (pad_out_o[PAM_PIN11] == gpio_out_i[PAM_PIN11])
                && (pad_oe_o[PAM_PIN11] == gpio_oe_i[PAM_PIN11]);
    endproperty
    a_pin11_port: assert property (p_pin11_port)
        else $error("pin eleven port route wrong");

    property p_pin10_rx0;
        @(posedge clk_i) disable iff (rst_i)
        (pin_ten_function_code == PAM_CODE_SERIAL)
            |-> !pad_oe_o[PAM_PIN10] && (serial0_receive_in_o == pad_in_i[PAM_PIN10]);
    endproperty
    a_pin10_rx0: assert property (p_pin10_rx0)
        else $error("serial0 receive not routed");

    property p_pin9_timer;
        @(posedge clk_i) disable iff (rst_i)
        (!emu_on && (pin_nine_function_code == PAM_CODE_TIMER))
            |-> !pad_oe_o[PAM_PIN9] && (timer_clock_d_in_o == pad_in_i[PAM_PIN9])
                && (output_disable_request_8_in_o == PAM_IN_IDLE);
    endproperty
    a_pin9_timer: assert property (p_pin9_timer)
        else $error("pin nine timer route wrong");

    property p_pin9_tx2;
        @(posedge clk_i) disable iff (rst_i)
        (!emu_on && (pin_nine_function_code == PAM_CODE_SERIAL))
            |-> pad_oe_o[PAM_PIN9] && (pad_out_o[PAM_PIN9] == serial2_transmit_out_i);
    endproperty
    a_pin9_tx2: assert property (p_pin9_tx2)
        else $error("pin nine serial route wrong");

    property p_pin8_rx2;
        @(posedge clk_i) disable iff (rst_i)
        (!emu_on && (pin_eight_function_code == PAM_CODE_SERIAL))
            |-> !pad_oe_o[PAM_PIN8] && (serial2_receive_in_o == pad_in_i[PAM_PIN8])
                && (timer_clock_c_in_o == PAM_IN_IDLE);
    endproperty
    a_pin8_rx2: assert property (p_pin8_rx2)
        else $error("pin eight serial route wrong");

    property p_pin8_port;
        @(posedge clk_i) disable iff (rst_i)
        (!emu_on && (pin_eight_function_code == PAM_CODE_PORT))
            |-> port_mode_o[PAM_PIN8] && (pad_oe_o[PAM_PIN8] == gpio_oe_i[PAM_PIN8])
                && (jtag_tdi_o == PAM_IN_IDLE);
    endproperty
    a_pin8_port: assert property (p_pin8_port)
        else $error("pin eight port route wrong");

    property p_emu_port_off;
        @(posedge clk_i) disable iff (rst_i)
        emu_on |-> !port_mode_o[PAM_PIN9] && !port_mode_o[PAM_PIN8];
    endproperty
    a_emu_port_off: assert property (p_emu_port_off)
        else $error("port mode kept under emulator");

endmodule

// *** pam_periph_model.sv ***
// stand-in for pads, port logic and peripherals around the pin function select
// assumes the bench clock and a synchronous active-high reset
`timescale 1ns/1ns
module pam_periph_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    output logic [3:0]       pad_in_o,
    output logic [3:0]       gpio_out_o,
    output logic [3:0]       gpio_oe_o,
    output logic [3:0]       drv_o
);
    logic [15:0] lfsr_ff;
    logic        nxt_bit;

    // every level comes from a 16-bit LFSR stepped each cycle, so a stale route seldom passes for a match
    assign nxt_bit = lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lfsr_ff <= 16'hace1;
        end else begin
            lfsr_ff <= {lfsr_ff[14:0], nxt_bit};
        end
    end

    assign pad_in_o   = lfsr_ff[3:0];
    assign gpio_out_o = lfsr_ff[7:4];
    assign gpio_oe_o  = lfsr_ff[11:8];
    // serial0 tx, serial2 tx, tdo, tdo enable
    assign drv_o      = lfsr_ff[15:12];
endmodule

// *** port_a_upper_pin_function_select_tb.sv ***
// self-checking bench of the upper port pin function select
// assumes pam_pkg, pam_pin_mux and pam_periph_model are compiled first
`timescale 1ns/1ns
module port_a_upper_pin_function_select_tb;
    import pam_pkg::*;
    logic        clk_i, rst_i, ce_i, emu_pin;
    pam_wb_req_t req;
    pam_wb_rsp_t rsp;
    logic [3:0]  pad_in, pad_out, pad_oe, gpio_out, gpio_oe, gpio_in, pm, pm2, drv;
    logic        trig, s0rx, s2rx, tcc, tcd, odr, tdi, ovr, ovr2;
    logic [15:0] v;
    int          n_fail, checks_done, seed_r;
    logic [31:0] expq [$];
    logic [2:0]  c8 [3] = '{3'h0, 3'h1, 3'h6};
    logic [2:0]  c9 [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
    logic [2:0]  c10 [2] = '{3'h0, 3'h6};
    logic [2:0]  c11 [3] = '{3'h0, 3'h2, 3'h6};

    pam_periph_model peri (.clk_i(clk_i), .rst_i(rst_i), .pad_in_o(pad_in),
        .gpio_out_o(gpio_out), .gpio_oe_o(gpio_oe), .drv_o(drv));
    pam_pin_mux uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .debug_emulator_mode_pin_i(emu_pin), .pad_in_i(pad_in), .pad_out_o(pad_out),
        .pad_oe_o(pad_oe), .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in),
        .serial0_transmit_out_i(drv[3]), .serial2_transmit_out_i(drv[2]),
        .jtag_tdo_i(drv[1]), .jtag_tdo_en_i(drv[0]), .converter_external_trigger_in_o(trig),
        .serial0_receive_in_o(s0rx), .serial2_receive_in_o(s2rx), .timer_clock_c_in_o(tcc),
        .timer_clock_d_in_o(tcd), .output_disable_request_8_in_o(odr), .jtag_tdi_o(tdi),
        .emulator_override_o(ovr), .port_mode_o(pm));
    pam_pin_mux #(.MEM_KBYTE(PAM_MEM_32K)) uut_small (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req), .wb_rsp_o(),
        .debug_emulator_mode_pin_i(emu_pin), .pad_in_i(pad_in), .pad_out_o(), .pad_oe_o(),
        .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .gpio_in_o(),
        .serial0_transmit_out_i(drv[3]), .serial2_transmit_out_i(drv[2]),
        .jtag_tdo_i(drv[1]), .jtag_tdo_en_i(drv[0]), .converter_external_trigger_in_o(),
        .serial0_receive_in_o(), .serial2_receive_in_o(), .timer_clock_c_in_o(),
        .timer_clock_d_in_o(), .output_disable_request_8_in_o(), .jtag_tdi_o(),
        .emulator_override_o(ovr2), .port_mode_o(pm2));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ==========================================================
    // compare, verdict and bus cycles
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d, input logic [31:0] exp);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
        if (!w) begin
            expq.push_back(exp);
        end
        // waits as long as it takes; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (rsp.ack !== 1'b1);
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // read data is judged by the watcher at the ack edge
    always @(posedge clk_i) begin
        if (rsp.ack === 1'b1 && req.we === 1'b0) begin
            cmp(rsp.dat, expq.size() > 0 ? expq.pop_front() : 32'hxxxx_xxxx);
        end
    end

    // expected pad and peripheral levels for a register value
    function automatic logic [23:0] route_exp(input logic [15:0] f, input logic emu);
        logic [3:0] oe, o, md;
        logic [6:0] pi;
        logic [2:0] c [4];
        for (int i = 0; i < 4; i++) begin
            c[i] = f[4*i +: 3];
            md[i] = (c[i] == PAM_CODE_PORT) && !(emu && i < PAM_PIN10);
            oe[i] = md[i] ? gpio_oe[i] : 1'b0;
        end
        oe[3] = oe[3] | (c[3] == PAM_CODE_SERIAL);
        oe[1] = emu ? drv[0] : (oe[1] | (c[1] == PAM_CODE_SERIAL));
        o = gpio_out & oe;
        o[3] = (c[3] == PAM_CODE_SERIAL) ? drv[3] : o[3];
        o[1] = emu ? (drv[1] & drv[0]) : ((c[1] == PAM_CODE_SERIAL) ? drv[2] : o[1]);
        pi[6] = (c[3] == PAM_CODE_TRIGGER) ? pad_in[3] : 1'b1;
        pi[5] = (c[2] == PAM_CODE_SERIAL) ? pad_in[2] : 1'b1;
        pi[4] = (c[0] == PAM_CODE_SERIAL && !emu) ? pad_in[0] : 1'b1;
        pi[3] = (c[0] == PAM_CODE_TIMER && !emu) ? pad_in[0] : 1'b1;
        pi[2] = (c[1] == PAM_CODE_TIMER && !emu) ? pad_in[1] : 1'b1;
        pi[1] = (c[1] == PAM_CODE_DISABLE && !emu) ? pad_in[1] : 1'b1;
        pi[0] = emu ? pad_in[0] : 1'b1;
        return {pad_in, oe, o, pi, md, emu};
    endfunction

    task automatic rchk(input logic [15:0] f);
        @(negedge clk_i);
        cmp({8'h00, gpio_in, pad_oe, pad_out & pad_oe, trig, s0rx, s2rx, tcc, tcd, odr, tdi,
             pm, ovr}, {8'h00, route_exp(f, emu_pin == PAM_EMU_ON)});
        @(posedge clk_i);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        emu_pin = ~PAM_EMU_ON;
        req = '0;
        seed_r = $urandom(32'hbf99f45a);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, PAM_ADR_FUNC, 4'hf, 32'h0, 32'h0);
        rchk(16'h0000);
        wb(1'b1, PAM_ADR_FUNC, 4'h3, 32'hffff_ae99, 32'h0);
        wb(1'b0, PAM_ADR_FUNC, 4'hf, 32'h0, 32'h0000_2611);
        rchk(16'h2611);
        for (int k = 0; k < 10; k++) begin
            v = k == 0 ? 16'h6066 : (k == 1 ? 16'h0670 : {1'b0, c11[$urandom % 3], 1'b0,
                c10[$urandom % 2], 1'b0, c9[$urandom % 4], 1'b0, c8[$urandom % 3]});
            wb(1'b1, PAM_ADR_FUNC, 4'h3, {16'h0, v}, 32'h0);
            wb(1'b0, PAM_ADR_FUNC, 4'hf, 32'h0, {16'h0, v});
            rchk(v);
        end
        wb(1'b1, PAM_ADR_FUNC, 4'h1, 32'h0000_6610, 32'h0);
        wb(1'b1, PAM_ADR_FUNC, 4'h2, 32'h0000_2055, 32'h0);
        wb(1'b1, 4'h4, 4'h3, 32'h0000_0666, 32'h0);
        wb(1'b0, 4'h4, 4'hf, 32'h0, 32'h0);
        wb(1'b0, PAM_ADR_FUNC, 4'hf, 32'h0, {16'h0, 8'h20, 8'h10});
        // a write standing while the clock enable is low must not land
        ce_i <= 1'b0;
        fork
            wb(1'b1, PAM_ADR_FUNC, 4'h3, 32'h0000_0111, 32'h0);
            begin
                repeat (3) @(posedge clk_i);
                rchk(16'h2010);
                cmp({31'h0, rsp.ack}, 32'h0);
                ce_i <= 1'b1;
            end
        join
        wb(1'b0, PAM_ADR_FUNC, 4'hf, 32'h0, 32'h0000_0111);
        rchk(16'h0111);
        wb(1'b1, PAM_ADR_FUNC, 4'h3, 32'h0000_0670, 32'h0);
        emu_pin <= PAM_EMU_ON;
        @(posedge clk_i);
        rchk(16'h0670);
        cmp({27'h0, ovr2, pm2}, {27'h0, 1'b0, 4'b1001});
        wb(1'b1, PAM_ADR_FUNC, 4'h3, 32'h0000_6066, 32'h0);
        rchk(16'h6066);
        emu_pin <= ~PAM_EMU_ON;
        @(posedge clk_i);
        rchk(16'h6066);
        repeat (20) @(posedge clk_i);
        rchk(16'h6066);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, PAM_ADR_FUNC, 4'hf, 32'h0, 32'h0);
        rchk(16'h0000);
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        wrap_up();
    end
endmodule
